//--- src/ceh_pkg.sv
// Shared constants for the command error handling block
package ceh_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATE    = 8'h04;
  localparam logic [7:0]  REG_ERRCNT   = 8'h08;
  localparam logic [7:0]  REG_ATOMIC   = 8'h0C;
  localparam logic [7:0]  REG_LASTSTAT = 8'h10;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_STOP_RD   = 0;
  localparam int          CTRL_STOP_WR   = 1;
  localparam int          CTRL_FATAL_EN  = 2;
  localparam int          CTRL_W         = 3;
  localparam logic [2:0]  CTRL_RESET     = 3'h4;
  localparam int          ST_FATAL       = 0;
  localparam int          ST_HOST_ABORT  = 1;
  localparam logic [15:0] ATOMIC_RESET   = 16'h0001;

  // ----------------------------------------------------------------
  // Error sources, index order equals ascending status code
  // ----------------------------------------------------------------
  localparam int ERR_XFER     = 0;
  localparam int ERR_INTERNAL = 1;
  localparam int ERR_SQDEL    = 2;
  localparam int ERR_WRFAULT  = 3;
  localparam int ERR_RDUNREC  = 4;
  localparam int ERR_GUARD    = 5;
  localparam int ERR_APPTAG   = 6;
  localparam int ERR_N        = 7;
  localparam int ERR_IDX_W    = 3;
  localparam int STAT_W       = 11;

  // Status = {type[2:0], code[7:0]}
  localparam logic [STAT_W-1:0] STAT_OK = 11'h000;
  localparam logic [STAT_W-1:0] STAT_TABLE [ERR_N] = '{
    11'h004, 11'h006, 11'h008, 11'h280, 11'h281, 11'h282, 11'h283};

  localparam int ID_W  = 16;
  localparam int BLK_W = 16;
  localparam int CNT_W = 16;

endpackage : ceh_pkg

//--- src/ceh_low_pick.sv
// Lowest-index set bit picker
`timescale 1ns/10ps
`default_nettype none
module ceh_low_pick #(
  parameter int N   = 7,
  parameter int IDX = 3
) (
  input  wire logic [N-1:0]   reqVec,
  output logic                anyHit,
  output logic [IDX-1:0]      lowIdx
);
  always_comb begin
    anyHit = 1'b0;
    lowIdx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (reqVec[i]) begin
        anyHit = 1'b1;
        lowIdx = IDX'(i);
      end
    end
  end
endmodule : ceh_low_pick
`default_nettype wire

//--- src/ceh_error_unit.sv
// Command error handling unit with AXI4-Lite register slave
//
// Behaviour
// - SQ delete aborts outstanding commands, frees resources
// - Keep processing; completion carries retry indication
// - Media failure completes with media status code
// - Read error: stop or finish DMA, error
// - Write error: stop or finish DMA
// - Small failed write keeps old data
// - Large failed write may return either data
// - Limited-retry setting selects recovery effort
// - Host memory fault halts command, needs host
// - Bad host pointer aborts with transfer error
// - Internal failures report lowest status code
// - Completion posting impossible sets fatal flag
// - Fatal flag raises no interrupt
`timescale 1ns/10ps
`default_nettype none
module ceh_error_unit
  import ceh_pkg::*;
#(
  parameter int ID_BITS = ceh_pkg::ID_W
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic                       ce,
  input  wire logic [ceh_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [ceh_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       errReport,
  input  wire logic                       cmdDone,
  input  wire logic [ID_BITS-1:0]         cmdId,
  input  wire logic                       cmdIsWrite,
  input  wire logic [ceh_pkg::BLK_W-1:0]  cmdBlocks,
  input  wire logic                       cmdLimRetry,
  input  wire logic [ceh_pkg::ERR_N-1:0]  errVec,
  input  wire logic                       sqDelReq,
  input  wire logic                       cqDelReq,
  input  wire logic [ID_BITS-1:0]         delQid,
  input  wire logic                       cplPostFail,
  output logic                            cplValid,
  output logic [ID_BITS-1:0]              cplCmdId,
  output logic [ceh_pkg::STAT_W-1:0]      cplStatus,
  output logic                            cplRetry,
  output logic                            dmaStop,
  output logic                            keepOldData,
  output logic                            recoverFull,
  output logic                            haltCmd,
  output logic                            sqAbortAll,
  output logic                            queueFree,
  output logic [ID_BITS-1:0]              freeQid,
  output logic                            fatalFaultFlag
);
  import ceh_pkg::*;

  // ----------------------------------------------------------------
  // Register bus state
  // ----------------------------------------------------------------
  logic                 awHeld_ff, nxt_awHeld;
  logic                 wHeld_ff, nxt_wHeld;
  logic [ADDR_W-1:0]    awAddr_ff, nxt_awAddr;
  logic [31:0]          wData_ff, nxt_wData;
  logic [3:0]           wStrb_ff, nxt_wStrb;
  logic                 bValid_ff, nxt_bValid;
  logic [1:0]           bResp_ff, nxt_bResp;
  logic                 rValid_ff, nxt_rValid;
  logic [31:0]          rData_ff, nxt_rData;
  logic [1:0]           rResp_ff, nxt_rResp;
  logic [CTRL_W-1:0]    ctrl_ff, nxt_ctrl;
  logic [BLK_W-1:0]     atomic_ff, nxt_atomic;

  // ----------------------------------------------------------------
  // Error handling state
  // ----------------------------------------------------------------
  logic                 fatal_ff, nxt_fatal;
  logic                 hostAbort_ff, nxt_hostAbort;
  logic [CNT_W-1:0]     errCnt_ff, nxt_errCnt;
  logic [STAT_W-1:0]    lastStat_ff, nxt_lastStat;
  logic [ERR_N-1:0]     pendErr_ff, nxt_pendErr;
  logic                 cplValid_ff, nxt_cplValid;
  logic [ID_BITS-1:0]   cplCmdId_ff, nxt_cplCmdId;
  logic [STAT_W-1:0]    cplStatus_ff, nxt_cplStatus;
  logic                 cplRetry_ff, nxt_cplRetry;
  logic                 dmaStop_ff, nxt_dmaStop;
  logic                 keepOld_ff, nxt_keepOld;
  logic                 recoverFull_ff, nxt_recoverFull;
  logic                 halt_ff, nxt_halt;
  logic                 sqAbort_ff, nxt_sqAbort;
  logic                 qFree_ff, nxt_qFree;
  logic [ID_BITS-1:0]   freeQid_ff, nxt_freeQid;

  logic                 doWrite;
  logic                 ctrlHit;
  logic                 stateHit;
  logic [ERR_N-1:0]     allErr;
  logic                 anyErr;
  logic [ERR_IDX_W-1:0] lowIdx;

  function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
                                             input logic [31:0] newV,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = oldV;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = newV[8*b +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign doWrite  = awHeld_ff && wHeld_ff && !bValid_ff;
  assign ctrlHit  = doWrite && (awAddr_ff == REG_CTRL);
  assign stateHit = doWrite && (awAddr_ff == REG_STATE);

  always_comb begin
    logic [31:0] merged;
    merged     = '0;
    nxt_awHeld = awHeld_ff;
    nxt_wHeld  = wHeld_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wData  = wData_ff;
    nxt_wStrb  = wStrb_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp  = bResp_ff;
    nxt_rValid = rValid_ff;
    nxt_rData  = rData_ff;
    nxt_rResp  = rResp_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_atomic = atomic_ff;
    // Address and data are caught independently, in either order
    if (s_axi_awvalid && !awHeld_ff) begin
      nxt_awHeld = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_ff) begin
      nxt_wHeld = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      nxt_awHeld = 1'b0;
      nxt_wHeld  = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp  = RESP_OKAY;
      unique case (awAddr_ff)
        REG_CTRL: begin
          merged   = mergeBytes({29'h0, ctrl_ff}, wData_ff, wStrb_ff);
          nxt_ctrl = merged[CTRL_W-1:0];
        end
        REG_ATOMIC: begin
          merged     = mergeBytes({16'h0, atomic_ff}, wData_ff, wStrb_ff);
          nxt_atomic = merged[BLK_W-1:0];
        end
        REG_STATE, REG_ERRCNT, REG_LASTSTAT: nxt_bResp = RESP_OKAY;
        default: nxt_bResp = RESP_SLVERR;
      endcase
    end
    if (bValid_ff && s_axi_bready) begin
      nxt_bValid = 1'b0;
    end
    if (rValid_ff && s_axi_rready) begin
      nxt_rValid = 1'b0;
    end else if (s_axi_arvalid && !rValid_ff) begin
      nxt_rValid = 1'b1;
      nxt_rResp  = RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL:     nxt_rData = {29'h0, ctrl_ff};
        REG_STATE:    nxt_rData = {30'h0, hostAbort_ff, fatal_ff};
        REG_ERRCNT:   nxt_rData = {16'h0, errCnt_ff};
        REG_ATOMIC:   nxt_rData = {16'h0, atomic_ff};
        REG_LASTSTAT: nxt_rData = {21'h0, lastStat_ff};
        default: begin
          nxt_rData = '0;
          nxt_rResp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= '0;
      wData_ff  <= '0;
      wStrb_ff  <= '0;
      bValid_ff <= 1'b0;
      bResp_ff  <= RESP_OKAY;
      rValid_ff <= 1'b0;
      rData_ff  <= '0;
      rResp_ff  <= RESP_OKAY;
      ctrl_ff   <= CTRL_RESET;
      atomic_ff <= ATOMIC_RESET;
    end else if (ce) begin
      awHeld_ff <= nxt_awHeld;
      wHeld_ff  <= nxt_wHeld;
      awAddr_ff <= nxt_awAddr;
      wData_ff  <= nxt_wData;
      wStrb_ff  <= nxt_wStrb;
      bValid_ff <= nxt_bValid;
      bResp_ff  <= nxt_bResp;
      rValid_ff <= nxt_rValid;
      rData_ff  <= nxt_rData;
      rResp_ff  <= nxt_rResp;
      ctrl_ff   <= nxt_ctrl;
      atomic_ff <= nxt_atomic;
    end
  end

  // Ready only while the slot is free and the clock runs, so a frozen cycle loses no beat
  always_comb begin
    s_axi_awready = ce && !awHeld_ff;
    s_axi_wready  = ce && !wHeld_ff;
    s_axi_arready = ce && !rValid_ff;
  end
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp  = bResp_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata  = rData_ff;
  assign s_axi_rresp  = rResp_ff;

  // ----------------------------------------------------------------
  // Error classification
  // ----------------------------------------------------------------
  assign allErr = pendErr_ff | errVec;

  ceh_low_pick #(
    .N   (ERR_N),
    .IDX (ERR_IDX_W)
  ) u_pick (
    .reqVec (allErr),
    .anyHit (anyErr),
    .lowIdx (lowIdx)
  );

  always_comb begin
    nxt_fatal       = fatal_ff;
    nxt_hostAbort   = hostAbort_ff;
    nxt_errCnt      = errCnt_ff;
    nxt_lastStat    = lastStat_ff;
    nxt_pendErr     = pendErr_ff;
    nxt_cplValid    = 1'b0;
    nxt_cplCmdId    = cplCmdId_ff;
    nxt_cplStatus   = cplStatus_ff;
    nxt_cplRetry    = cplRetry_ff;
    nxt_dmaStop     = 1'b0;
    nxt_keepOld     = keepOld_ff;
    nxt_recoverFull = !cmdLimRetry;
    nxt_halt        = 1'b0;
    nxt_sqAbort     = 1'b0;
    nxt_qFree       = 1'b0;
    nxt_freeQid     = freeQid_ff;
    if (errReport) begin
      nxt_pendErr = pendErr_ff | errVec;
      // DMA stop follows the software policy bit and always happens on a transfer error; otherwise the transfer finishes
      nxt_dmaStop = errVec[ERR_XFER]
                  | (cmdIsWrite ? ctrl_ff[CTRL_STOP_WR]
                                : ctrl_ff[CTRL_STOP_RD]);
      nxt_halt    = errVec[ERR_XFER];
    end
    if (cmdDone) begin
      nxt_pendErr   = '0;
      nxt_cplValid  = 1'b1;
      nxt_cplCmdId  = cmdId;
      nxt_cplStatus = anyErr ? STAT_TABLE[lowIdx] : STAT_OK;
      // No retry hope for bad pointers or when recovery was limited
      nxt_cplRetry  = anyErr && !allErr[ERR_XFER] && !cmdLimRetry;
      nxt_keepOld   = anyErr && cmdIsWrite && (cmdBlocks <= atomic_ff);
      if (anyErr) begin
        nxt_errCnt   = errCnt_ff + 1'b1;
        nxt_lastStat = STAT_TABLE[lowIdx];
      end
    end
    if (doWrite && (awAddr_ff == REG_ERRCNT)) begin
      nxt_errCnt = '0;
    end
    if (stateHit && wStrb_ff[0] && wData_ff[ST_HOST_ABORT]) begin
      nxt_hostAbort = 1'b0;
    end
    // Set wins over the software clear in the same cycle
    if ((errReport || cmdDone) && errVec[ERR_XFER]) begin
      nxt_hostAbort = 1'b1;
    end
    if (sqDelReq) begin
      nxt_sqAbort = 1'b1;
    end
    if (sqDelReq || cqDelReq) begin
      nxt_qFree   = 1'b1;
      nxt_freeQid = delQid;
    end
    // Sticky until reset; there is no interrupt path at all
    if (cplPostFail && ctrl_ff[CTRL_FATAL_EN]) begin
      nxt_fatal = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fatal_ff       <= 1'b0;
      hostAbort_ff   <= 1'b0;
      errCnt_ff      <= '0;
      lastStat_ff    <= STAT_OK;
      pendErr_ff     <= '0;
      cplValid_ff    <= 1'b0;
      cplCmdId_ff    <= '0;
      cplStatus_ff   <= STAT_OK;
      cplRetry_ff    <= 1'b0;
      dmaStop_ff     <= 1'b0;
      keepOld_ff     <= 1'b0;
      recoverFull_ff <= 1'b0;
      halt_ff        <= 1'b0;
      sqAbort_ff     <= 1'b0;
      qFree_ff       <= 1'b0;
      freeQid_ff     <= '0;
    end else if (ce) begin
      fatal_ff       <= nxt_fatal;
      hostAbort_ff   <= nxt_hostAbort;
      errCnt_ff      <= nxt_errCnt;
      lastStat_ff    <= nxt_lastStat;
      pendErr_ff     <= nxt_pendErr;
      cplValid_ff    <= nxt_cplValid;
      cplCmdId_ff    <= nxt_cplCmdId;
      cplStatus_ff   <= nxt_cplStatus;
      cplRetry_ff    <= nxt_cplRetry;
      dmaStop_ff     <= nxt_dmaStop;
      keepOld_ff     <= nxt_keepOld;
      recoverFull_ff <= nxt_recoverFull;
      halt_ff        <= nxt_halt;
      sqAbort_ff     <= nxt_sqAbort;
      qFree_ff       <= nxt_qFree;
      freeQid_ff     <= nxt_freeQid;
    end
  end

  assign cplValid       = cplValid_ff;
  assign cplCmdId       = cplCmdId_ff;
  assign cplStatus      = cplStatus_ff;
  assign cplRetry       = cplRetry_ff;
  assign dmaStop        = dmaStop_ff;
  assign keepOldData    = keepOld_ff;
  assign recoverFull    = recoverFull_ff;
  assign haltCmd        = halt_ff;
  assign sqAbortAll     = sqAbort_ff;
  assign queueFree      = qFree_ff;
  assign freeQid        = freeQid_ff;
  assign fatalFaultFlag = fatal_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_sq_abort: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && sqDelReq |=> sqAbortAll && queueFree && freeQid == $past(delQid))
    else $error("queue delete not acted on");
  a_cpl_follows: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && cmdDone |=> cplValid && cplCmdId == $past(cmdId))
    else $error("completion missing");
  a_media_code: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && cmdDone && pendErr_ff == '0 && errVec == 7'h10 |=> cplStatus == 11'h281)
    else $error("media status wrong");
  a_xfer_code: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && cmdDone && errVec[ERR_XFER] |=> cplStatus == 11'h004 && !cplRetry)
    else $error("bad pointer status wrong");
  a_lowest_code: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && cmdDone && allErr[ERR_INTERNAL] && !allErr[ERR_XFER] |=> cplStatus == 11'h006)
    else $error("internal not lowest");
  a_read_stop: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && errReport && !cmdIsWrite && ctrl_ff[CTRL_STOP_RD] |=> dmaStop)
    else $error("read dma not stopped");
  a_atomic_keep: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && cmdDone && cmdIsWrite && anyErr && cmdBlocks <= atomic_ff |=> keepOldData)
    else $error("atomic write not kept");
  a_fatal_set: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && cplPostFail && ctrl_ff[CTRL_FATAL_EN] |=> fatalFaultFlag [*3])
    else $error("fatal flag not set");
  a_fatal_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(fatalFaultFlag) |-> fatalFaultFlag)
    else $error("fatal flag dropped");

endmodule : ceh_error_unit
`default_nettype wire

//--- bench/ceh_host_model.sv
// Host software policy model: trusts data only from clean completions and requests reset on fatal
`timescale 1ns/10ps
`default_nettype none
module ceh_host_model
  import ceh_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  input  wire logic                      cplValid,
  input  wire logic [ceh_pkg::STAT_W-1:0] cplStatus,
  input  wire logic                      fatalFaultFlag,
  output logic                           dataUsable,
  output logic                           wantReset
);
  import ceh_pkg::*;

  // Any error status leaves the moved data untrusted, so only clean completions count
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dataUsable <= 1'b0;
      wantReset  <= 1'b0;
    end else begin
      if (cplValid) dataUsable <= (cplStatus == STAT_OK);
      if (fatalFaultFlag) wantReset <= 1'b1;
    end
  end
endmodule : ceh_host_model
`default_nettype wire

//--- bench/command_error_handling_test.sv
// Self-checking bench for the command error handling unit
`timescale 1ns/10ps
`default_nettype none
module command_error_handling_test;
  import ceh_pkg::*;
  logic        mclk, rst_b, ce, errReport, cmdDone, cmdIsWrite, cmdLimRetry;
  logic        sqDelReq, cqDelReq, cplPostFail, cplValid, cplRetry, dmaStop, keepOldData;
  logic        recoverFull, haltCmd, sqAbortAll, queueFree, fatalFaultFlag, dataUsable, wantReset;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] cmdId, cmdBlocks, delQid, cplCmdId, freeQid;
  logic [6:0]  errVec;
  logic [10:0] cplStatus;
  int          errors, cmpCount, i;

  ceh_error_unit uut (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .errReport(errReport), .cmdDone(cmdDone), .cmdId(cmdId),
    .cmdIsWrite(cmdIsWrite), .cmdBlocks(cmdBlocks), .cmdLimRetry(cmdLimRetry), .errVec(errVec),
    .sqDelReq(sqDelReq), .cqDelReq(cqDelReq), .delQid(delQid), .cplPostFail(cplPostFail),
    .cplValid(cplValid), .cplCmdId(cplCmdId), .cplStatus(cplStatus), .cplRetry(cplRetry),
    .dmaStop(dmaStop), .keepOldData(keepOldData), .recoverFull(recoverFull), .haltCmd(haltCmd),
    .sqAbortAll(sqAbortAll), .queueFree(queueFree), .freeQid(freeQid),
    .fatalFaultFlag(fatalFaultFlag));

  ceh_host_model host (
    .mclk(mclk), .rst_b(rst_b), .cplValid(cplValid), .cplStatus(cplStatus),
    .fatalFaultFlag(fatalFaultFlag), .dataUsable(dataUsable), .wantReset(wantReset));

  // ----------------------------------------------------------------
  // Bus and command tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (errors == 0 && cmpCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask : chk

  // Ready is sampled at the falling edge; it cannot change before the next rising edge
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && b; n++) begin
      @(negedge mclk);
      if (aw && s_axi_awready) aw = 1'b0;
      if (w && s_axi_wready) w = 1'b0;
      if (!aw && !w && s_axi_bvalid) begin
        rsp = s_axi_bresp;
        b = 1'b0;
      end
      @(posedge mclk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      s_axi_bready <= b;
    end
    if (b) begin
      errors++;
      finish_test();
    end
  endtask : axiWr

  task automatic axiRd(input logic [7:0] a);
    logic ar, r;
    ar = 1'b1;
    r = 1'b1;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && r; n++) begin
      @(negedge mclk);
      if (ar && s_axi_arready) ar = 1'b0;
      if (!ar && s_axi_rvalid) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        r = 1'b0;
      end
      @(posedge mclk);
      s_axi_arvalid <= ar;
      s_axi_rready <= r;
    end
    if (r) begin
      errors++;
      finish_test();
    end
  endtask : axiRd

  // Completion is looked at in its single valid cycle
  task automatic cmd(input logic [6:0] ev, input logic wr, input logic lim, input logic [15:0] blk);
    @(posedge mclk);
    errVec <= ev;
    cmdIsWrite <= wr;
    cmdLimRetry <= lim;
    cmdBlocks <= blk;
    cmdId <= cmdId + 16'h0001;
    cmdDone <= 1'b1;
    @(posedge mclk);
    cmdDone <= 1'b0;
    errVec <= 7'h00;
    @(negedge mclk);
  endtask : cmd

  task automatic errPulse(input logic [6:0] ev, input logic wr);
    @(posedge mclk);
    errVec <= ev;
    cmdIsWrite <= wr;
    errReport <= 1'b1;
    @(posedge mclk);
    errReport <= 1'b0;
    errVec <= 7'h00;
    @(negedge mclk);
  endtask : errPulse

  task automatic qDel(input logic sq, input logic [15:0] q);
    @(posedge mclk);
    delQid <= q;
    sqDelReq <= sq;
    cqDelReq <= !sq;
    @(posedge mclk);
    sqDelReq <= 1'b0;
    cqDelReq <= 1'b0;
    @(negedge mclk);
    chk({sqAbortAll, queueFree, freeQid}, {sq, 1'b1, q});
  endtask : qDel

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    {rst_b, errReport, cmdDone, cmdIsWrite, cmdLimRetry, sqDelReq, cqDelReq, cplPostFail} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmdId, cmdBlocks, delQid, errVec} = '0;
    {errors, cmpCount} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    axiRd(REG_CTRL);
    chk(rd, {29'h0, CTRL_RESET});
    axiRd(REG_ATOMIC);
    chk(rd, {16'h0, ATOMIC_RESET});
    axiRd(8'h14);
    chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    axiWr(8'h18, 32'h7);
    chk(rsp, RESP_SLVERR);
    axiWr(REG_CTRL, 32'h0);
    @(posedge mclk) cplPostFail <= 1'b1;
    @(posedge mclk) cplPostFail <= 1'b0;
    @(negedge mclk) chk(fatalFaultFlag, 1'b0);
    axiWr(REG_CTRL, 32'h7);
    chk(rsp, RESP_OKAY);
    for (i = 0; i < ERR_N; i++) begin
      cmd(7'h01 << i, 1'b0, 1'b0, 16'h0001);
      chk({cplValid, cplCmdId, cplStatus}, {1'b1, cmdId, STAT_TABLE[i]});
      chk({cplRetry, recoverFull}, {i != ERR_XFER, 1'b1});
    end
    cmd(7'h7E, 1'b0, 1'b1, 16'h0001);
    chk({cplStatus, cplRetry, recoverFull}, {STAT_TABLE[ERR_INTERNAL], 2'b00});
    cmd(7'h7F, 1'b0, 1'b0, 16'h0001);
    chk(cplStatus, STAT_TABLE[ERR_XFER]);
    axiRd(REG_LASTSTAT);
    chk(rd, {21'h0, STAT_TABLE[ERR_XFER]});
    chk(dataUsable, 1'b0);
    axiRd(REG_ERRCNT);
    chk(rd, 32'h9);
    axiWr(REG_ERRCNT, 32'h0);
    axiRd(REG_ERRCNT);
    chk(rd, 32'h0);
    cmd(7'h00, 1'b0, 1'b0, 16'h0001);
    chk({cplValid, cplStatus, cplRetry}, {1'b1, STAT_OK, 1'b0});
    @(negedge mclk) chk(dataUsable, 1'b1);
    for (i = 0; i < 4; i++) begin
      if (i == 2) axiWr(REG_ATOMIC, 32'h4);
      cmd(7'h08, 1'b1, 1'b0, 16'(i < 2 ? i + 1 : i + 2));
      chk(keepOldData, i % 2 == 0);
    end
    errPulse(7'h10, 1'b0);
    chk(dmaStop, 1'b1);
    cmd(7'h00, 1'b0, 1'b0, 16'h0001);
    chk(cplStatus, STAT_TABLE[ERR_RDUNREC]);
    errPulse(7'h08, 1'b1);
    chk(dmaStop, 1'b1);
    cmd(7'h00, 1'b1, 1'b0, 16'h0001);
    axiWr(REG_CTRL, 32'h4);
    errPulse(7'h10, 1'b0);
    chk(dmaStop, 1'b0);
    // Clear the abort flag left by an earlier completion so the pulse below must set it
    axiWr(REG_STATE, 32'h2);
    errPulse(7'h01, 1'b0);
    chk(haltCmd, 1'b1);
    axiRd(REG_STATE);
    chk(rd[ST_HOST_ABORT], 1'b1);
    cmd(7'h00, 1'b0, 1'b0, 16'h0001);
    chk(cplStatus, STAT_TABLE[ERR_XFER]);
    axiWr(REG_STATE, 32'h2);
    axiRd(REG_STATE);
    chk(rd[ST_HOST_ABORT], 1'b0);
    qDel(1'b1, 16'h0005);
    qDel(1'b0, 16'h0006);
    @(posedge mclk) cplPostFail <= 1'b1;
    @(posedge mclk) cplPostFail <= 1'b0;
    @(negedge mclk) chk(fatalFaultFlag, 1'b1);
    repeat (10) @(posedge mclk);
    axiRd(REG_STATE);
    chk({rd[ST_FATAL], fatalFaultFlag, wantReset}, 3'b111);
    if (wantReset) rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk) chk(fatalFaultFlag, 1'b0);
    axiRd(REG_CTRL);
    chk(rd, {29'h0, CTRL_RESET});
    finish_test();
  end
endmodule : command_error_handling_test
`default_nettype wire
